// >>> shared/decoder_params.svh
// Constants for the byte-operation instruction decoder: fields, opcodes, flag masks.
// What this block does
// RQ1: Destination bit 0 sends result to accumulator, 1 back to file register.
// RQ2: Bank access bit 0 forces access bank, 1 lets bank select choose.
// RQ3: Byte and bit operations carry an 8-bit file address in the low byte.
// RQ4: File-to-file move: 12-bit source after 1100, destination from 1111 word, 2 cycles.
// RQ5: Bit operations carry a 3-bit bit-position field.
// RQ6: Literal operations take an 8-bit immediate from the low byte.
// RQ7: Call and jump assemble a 20-bit target over two words; call has fast bit.
// RQ8: Unconditional branch uses 11-bit offset, conditional branches 8-bit offset.
// RQ9: Prefix 0010 01 adds, 0010 00 adds with carry; one cycle, five flags.
// RQ10: Prefix 0001 gives and, or, xor, complement; one cycle, zero and negative.
// RQ11: 0000 001 is unsigned multiply, one cycle, no flags changed.
// RQ12: Prefix 0110 gives compares, test, set, clear, negate, store accumulator.
// RQ13: Decrement, increment and their skip variants with their flag effects.
// RQ14: Rotates with and without carry and nibble swap with their flag effects.
// RQ15: Prefix 0101 gives the three subtracts and copy file.
// RQ16: A port modified as a function of itself reads pin levels.
// RQ17: A flagged write to the timer zero register clears its assigned prescaler.
// RQ18: Program counter change or true test takes two cycles, second a no-operation; of the branches only 1101 0 is flushed, and call and jump take three.
// RQ19: A lone second word is a no-operation; skips over two-word take three cycles.
// RQ20: Fast bit 1 saves or restores shadows; 0 leaves shadows untouched. The code sets fast_shadow_o only for call and decodes no restore.
// RQ21: Banked full address is four bank bits above the 8-bit file address.
// RQ22: Operations without destination bit write the file, except compare, test, multiply.
`ifndef DECODER_PARAMS_SVH
`define DECODER_PARAMS_SVH
`define DST_BIT 9
`define BANK_BIT 8
`define FAST_BIT 8
`define PFX_MOVE2 4'hc
`define PFX_SECOND 4'hf
`define PFX_CTRL 4'he
`define PFX_BRA 4'hd
`define SUB_CALL 3'h6
`define SUB_ABSOLUTE_JUMP 4'hf
`define ACCESS_BANK 4'h0
`define FLAG_C 0
`define FLAG_DC 1
`define FLAG_Z 2
`define FLAG_OV 3
`define FLAG_N 4
`define FLAGS_ALL 5'h1f
`define FLAGS_ZN 5'h14
`define FLAGS_CZN 5'h15
`define FLAGS_Z 5'h04
`define FLAGS_NONE 5'h00
`endif

// >>> shared/decoder_pkg.sv
// Types shared by the instruction decoder.
package decoder_pkg;
    typedef enum logic [4:0] {
        ALU_NONE = 5'h00, ALU_ADD = 5'h01, ALU_ADDC = 5'h02, ALU_AND = 5'h03,
        ALU_OR = 5'h04, ALU_XOR = 5'h05, ALU_COM = 5'h06, ALU_MUL = 5'h07,
        ALU_CPLT = 5'h08, ALU_CPEQ = 5'h09, ALU_CPGT = 5'h0a, ALU_TST = 5'h0b,
        ALU_SET = 5'h0c, ALU_CLR = 5'h0d, ALU_NEG = 5'h0e, ALU_STORE = 5'h0f,
        ALU_DEC = 5'h10, ALU_INC = 5'h11, ALU_DECSZ = 5'h12, ALU_DECSNZ = 5'h13,
        ALU_INCSZ = 5'h14, ALU_INCSNZ = 5'h15, ALU_RLC = 5'h16, ALU_RRC = 5'h17,
        ALU_RL = 5'h18, ALU_RR = 5'h19, ALU_SWAP = 5'h1a, ALU_SUB = 5'h1b,
        ALU_SUBB = 5'h1c, ALU_SUBFB = 5'h1d, ALU_COPY = 5'h1e, ALU_MOVE2 = 5'h1f
    } alu_op_e;
    typedef enum logic [3:0] {
        ST_FIRST = 4'b0001,
        ST_MOVE2 = 4'b0010,
        ST_JUMP2 = 4'b0100,
        ST_FLUSH = 4'b1000
    } dec_state_e;
endpackage

// >>> rtl/byte_op_instruction_decoder.sv
// Instruction decoder for byte-oriented and format-level fields of the core.
`timescale 1ns/100ps
`include "decoder_params.svh"
module byte_op_instruction_decoder
    import decoder_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic [3:0] bank_select_register_i,
    input wire logic test_true_i,
    input wire logic timer_zero_prescaler_assigned_i,
    input wire logic [11:0] timer_zero_count_addr_i,
    input wire logic [11:0] port_addr_lo_i,
    input wire logic [11:0] port_addr_hi_i,
    output logic [4:0] alu_op_o,
    output logic op_valid_o,
    output logic dest_to_acc_o,
    output logic file_write_o,
    output logic [11:0] file_addr_o,
    output logic [11:0] move_dst_addr_o,
    output logic [2:0] bit_sel_o,
    output logic [7:0] literal_o,
    output logic [19:0] jump_target_o,
    output logic jump_valid_o,
    output logic fast_shadow_o,
    output logic [10:0] branch_offset_o,
    output logic [4:0] flag_mask_o,
    output logic read_pins_o,
    output logic prescaler_clear_o,
    output logic no_operation_o,
    output logic multi_cycle_o
);
    dec_state_e state_r;
    dec_state_e state_nxt;
    alu_op_e op_nxt;
    logic [4:0] mask_nxt;
    logic has_dest;
    logic writes_file;
    logic reads_self;
    logic dest_acc;
    logic [11:0] addr_nxt;
    logic [3:0] pfx;
    logic [7:0] first_lo_r;
    logic fast_r;
    logic is_skip;

    assign pfx = instr_i[15:12];

    // Classify the byte-oriented opcode and pick its flag effects.
    always_comb
    begin
        op_nxt = ALU_NONE;
        mask_nxt = `FLAGS_NONE;
        has_dest = 1'b1;
        is_skip = 1'b0;
        unique case (pfx)
            4'h0:
            begin
                if (instr_i[11:9] == 3'h1)
                begin
                    op_nxt = ALU_MUL; // [RQ11]
                    has_dest = 1'b0;
                end
                else if (instr_i[11:10] == 2'h1)
                begin
                    op_nxt = ALU_DEC; // [RQ13]
                    mask_nxt = `FLAGS_ALL;
                end
            end
            4'h1:
            begin
                mask_nxt = `FLAGS_ZN; // [RQ10]
                unique case (instr_i[11:10])
                    2'h0: op_nxt = ALU_OR;
                    2'h1: op_nxt = ALU_AND;
                    2'h2: op_nxt = ALU_XOR;
                    2'h3: op_nxt = ALU_COM;
                endcase
            end
            4'h2:
            begin
                unique case (instr_i[11:10])
                    2'h0: op_nxt = ALU_ADDC; // [RQ9]
                    2'h1: op_nxt = ALU_ADD; // [RQ9]
                    2'h2: op_nxt = ALU_INC; // [RQ13]
                    2'h3: op_nxt = ALU_DECSZ; // [RQ13]
                endcase
                mask_nxt = (instr_i[11:10] == 2'h3) ? `FLAGS_NONE : `FLAGS_ALL;
                is_skip = (instr_i[11:10] == 2'h3);
            end
            4'h3:
            begin
                unique case (instr_i[11:10])
                    2'h0: op_nxt = ALU_RRC; // [RQ14]
                    2'h1: op_nxt = ALU_RLC; // [RQ14]
                    2'h2: op_nxt = ALU_SWAP; // [RQ14]
                    2'h3: op_nxt = ALU_INCSZ; // [RQ13]
                endcase
                mask_nxt = instr_i[11] ? `FLAGS_NONE : `FLAGS_CZN;
                is_skip = (instr_i[11:10] == 2'h3);
            end
            4'h4:
            begin
                unique case (instr_i[11:10])
                    2'h0: op_nxt = ALU_RR; // [RQ14]
                    2'h1: op_nxt = ALU_RL; // [RQ14]
                    2'h2: op_nxt = ALU_INCSNZ; // [RQ13]
                    2'h3: op_nxt = ALU_DECSNZ; // [RQ13]
                endcase
                mask_nxt = instr_i[11] ? `FLAGS_NONE : `FLAGS_ZN;
                is_skip = instr_i[11];
            end
            4'h5:
            begin
                unique case (instr_i[11:10])
                    2'h0: op_nxt = ALU_COPY; // [RQ15]
                    2'h1: op_nxt = ALU_SUBFB; // [RQ15]
                    2'h2: op_nxt = ALU_SUBB; // [RQ15]
                    2'h3: op_nxt = ALU_SUB; // [RQ15]
                endcase
                mask_nxt = (instr_i[11:10] == 2'h0) ? `FLAGS_ZN : `FLAGS_ALL;
            end
            4'h6:
            begin
                has_dest = 1'b0;
                unique case (instr_i[11:9])
                    3'h0: op_nxt = ALU_CPLT; // [RQ12]
                    3'h1: op_nxt = ALU_CPEQ; // [RQ12]
                    3'h2: op_nxt = ALU_CPGT; // [RQ12]
                    3'h3: op_nxt = ALU_TST; // [RQ12]
                    3'h4: op_nxt = ALU_SET; // [RQ12]
                    3'h5: op_nxt = ALU_CLR; // [RQ12]
                    3'h6: op_nxt = ALU_NEG; // [RQ12]
                    3'h7: op_nxt = ALU_STORE; // [RQ12]
                endcase
                if (instr_i[11:9] == 3'h5)
                    mask_nxt = `FLAGS_Z;
                else if (instr_i[11:9] == 3'h6)
                    mask_nxt = `FLAGS_ALL;
                is_skip = (instr_i[11] == 1'b0);
            end
            4'hc: op_nxt = ALU_MOVE2; // [RQ4]
            default: op_nxt = ALU_NONE;
        endcase
    end

    // Destination and file-write decisions.
    always_comb
    begin
        dest_acc = has_dest & ~instr_i[`DST_BIT]; // [RQ1]
        writes_file = 1'b0;
        if (op_nxt == ALU_MOVE2 || op_nxt == ALU_NONE)
            writes_file = 1'b0;
        else if (has_dest)
            writes_file = instr_i[`DST_BIT]; // [RQ1]
        else
            writes_file = !(op_nxt inside {ALU_CPLT, ALU_CPEQ, ALU_CPGT, ALU_TST, ALU_MUL}); // [RQ22]
        // Only a write whose result depends on the old file value reads the pins back.
        reads_self = writes_file && !(op_nxt inside {ALU_STORE, ALU_SET, ALU_CLR}); // [RQ16]
    end

    // Banked address: access bank when a is 0, bank select above f when 1.
    assign addr_nxt = instr_i[`BANK_BIT] ? {bank_select_register_i, instr_i[7:0]} // [RQ2] [RQ21]
                                         : {`ACCESS_BANK, instr_i[7:0]}; // [RQ2] [RQ3]

    // Word sequencer: second words, flush cycles after jumps and unconditional branches.
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_FIRST:
                if (instr_valid_i)
                begin
                    if (pfx == `PFX_MOVE2)
                        state_nxt = ST_MOVE2; // [RQ4]
                    else if (pfx == `PFX_CTRL && (instr_i[11:9] == `SUB_CALL
                             || instr_i[11:8] == `SUB_ABSOLUTE_JUMP))
                        state_nxt = ST_JUMP2; // [RQ7]
                    else if (pfx == `PFX_BRA && !instr_i[11])
                        state_nxt = ST_FLUSH; // [RQ18]
                end
            ST_MOVE2:
                if (instr_valid_i)
                    state_nxt = ST_FIRST;
            ST_JUMP2:
                if (instr_valid_i)
                    state_nxt = ST_FLUSH; // [RQ18]
            ST_FLUSH:
                if (instr_valid_i)
                    state_nxt = ST_FIRST;
            default: state_nxt = ST_FIRST;
        endcase
    end

    // State register; a true skip test also costs a flush cycle.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_r <= ST_FIRST;
        else if (state_r == ST_FIRST && instr_valid_i && test_true_i && is_skip)
            state_r <= ST_FLUSH; // [RQ18]
        else
            state_r <= state_nxt;
    end

    // Hold first-word fields for two-word instructions.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            first_lo_r <= 8'h00;
            fast_r <= 1'b0;
        end
        else if (state_r == ST_FIRST && instr_valid_i)
        begin
            first_lo_r <= instr_i[7:0]; // [RQ7]
            fast_r <= instr_i[`FAST_BIT] & (instr_i[11:9] == `SUB_CALL); // [RQ7]
        end
    end

    // Registered decode outputs.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            alu_op_o <= 5'h00;
            op_valid_o <= 1'b0;
            dest_to_acc_o <= 1'b0;
            file_write_o <= 1'b0;
            file_addr_o <= 12'h000;
            move_dst_addr_o <= 12'h000;
            bit_sel_o <= 3'h0;
            literal_o <= 8'h00;
            jump_target_o <= 20'h00000;
            jump_valid_o <= 1'b0;
            fast_shadow_o <= 1'b0;
            branch_offset_o <= 11'h000;
            flag_mask_o <= 5'h00;
            read_pins_o <= 1'b0;
            prescaler_clear_o <= 1'b0;
            no_operation_o <= 1'b0;
            multi_cycle_o <= 1'b0;
        end
        else
        begin
            op_valid_o <= 1'b0;
            jump_valid_o <= 1'b0;
            fast_shadow_o <= 1'b0;
            prescaler_clear_o <= 1'b0;
            file_write_o <= 1'b0;
            no_operation_o <= 1'b0;
            if (instr_valid_i)
            begin
                unique case (state_r)
                    ST_FIRST:
                    begin
                        alu_op_o <= op_nxt;
                        op_valid_o <= (op_nxt != ALU_NONE) && (op_nxt != ALU_MOVE2);
                        dest_to_acc_o <= dest_acc; // [RQ1]
                        file_write_o <= writes_file; // [RQ22]
                        file_addr_o <= (pfx == `PFX_MOVE2) ? instr_i[11:0] : addr_nxt; // [RQ4]
                        bit_sel_o <= instr_i[11:9]; // [RQ5]
                        literal_o <= instr_i[7:0]; // [RQ6]
                        flag_mask_o <= mask_nxt;
                        branch_offset_o <= (pfx == `PFX_BRA) ? instr_i[10:0] // [RQ8]
                                                             : {3'h0, instr_i[7:0]}; // [RQ8]
                        read_pins_o <= reads_self && addr_nxt >= port_addr_lo_i
                                       && addr_nxt <= port_addr_hi_i; // [RQ16]
                        prescaler_clear_o <= writes_file && timer_zero_prescaler_assigned_i
                                             && addr_nxt == timer_zero_count_addr_i; // [RQ17]
                        multi_cycle_o <= (state_nxt != ST_FIRST) || (test_true_i && is_skip); // [RQ18]
                    end
                    ST_MOVE2:
                    begin
                        alu_op_o <= ALU_MOVE2;
                        op_valid_o <= (pfx == `PFX_SECOND); // [RQ4]
                        move_dst_addr_o <= instr_i[11:0]; // [RQ4]
                        file_write_o <= (pfx == `PFX_SECOND);
                        prescaler_clear_o <= timer_zero_prescaler_assigned_i
                                             && instr_i[11:0] == timer_zero_count_addr_i; // [RQ17]
                        multi_cycle_o <= 1'b0;
                    end
                    ST_JUMP2:
                    begin
                        jump_target_o <= {instr_i[11:0], first_lo_r}; // [RQ7]
                        jump_valid_o <= (pfx == `PFX_SECOND);
                        fast_shadow_o <= fast_r; // [RQ20]
                    end
                    ST_FLUSH:
                    begin
                        no_operation_o <= 1'b1; // [RQ18] [RQ19]
                        multi_cycle_o <= 1'b0;
                    end
                    default: no_operation_o <= 1'b1;
                endcase
                // A lone second word is executed as a no-operation.
                if (state_r == ST_FIRST && pfx == `PFX_SECOND)
                    no_operation_o <= 1'b1; // [RQ19]
            end
        end
    end
endmodule

// >>> dv/fetch_model.sv
// Program memory fetch model that presents instruction words to the decoder.
`timescale 1ns/100ps
module fetch_model
(
    input wire logic clk_i,
    output logic [15:0] instr_o,
    output logic instr_valid_o,
    output logic test_true_o
);
    // Nothing is presented until the first word is sent.
    initial
    begin
        instr_o = 16'h0000;
        instr_valid_o = 1'b0;
        test_true_o = 1'b0;
    end
    // Presents one word for one cycle with its skip test result.
    task automatic send(input logic [15:0] w, input logic t);
        @(negedge clk_i);
        instr_o <= w;
        instr_valid_o <= 1'b1;
        test_true_o <= t;
    endtask
    // Idle bus shows the inverse of the last word, so stale data is never reused.
    task automatic idle();
        @(negedge clk_i);
        instr_o <= ~instr_o;
        instr_valid_o <= 1'b0;
        test_true_o <= 1'b0;
    endtask
endmodule

// >>> dv/byte_op_instruction_decoder_monitor.sv
// Concurrent checks on the decoder's ports.
`timescale 1ns/100ps
module byte_op_instruction_decoder_monitor
    import decoder_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic [3:0] bank_select_register_i,
    input wire logic test_true_i,
    input wire logic [4:0] alu_op_o,
    input wire logic op_valid_o,
    input wire logic dest_to_acc_o,
    input wire logic file_write_o,
    input wire logic [11:0] file_addr_o,
    input wire logic [11:0] move_dst_addr_o,
    input wire logic [19:0] jump_target_o,
    input wire logic jump_valid_o,
    input wire logic fast_shadow_o,
    input wire logic [4:0] flag_mask_o,
    input wire logic no_operation_o
);
    logic [1:0] skip_r;
    logic take;
    logic byte_d;
    // A word is a first word only when no second or flushed word is still owed.
    assign take = instr_valid_i && skip_r == 2'h0;
    assign byte_d = take && instr_i[15:12] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
    // Counts the words that follow a two-word, branch or true skip first word.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            skip_r <= 2'h0;
        end
        else if (instr_valid_i && skip_r != 2'h0)
        begin
            skip_r <= skip_r - 2'h1;
        end
        else if (take)
        begin
            skip_r <= (instr_i[15:9] == 7'h76 || instr_i[15:8] == 8'hef) ? 2'h2 :
                (instr_i[15:12] == 4'hc || instr_i[15:11] == 5'h1a || test_true_i);
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Two-word transfers in their legal back-to-back order.
    sequence move_pair;
        take && instr_i[15:12] == 4'hc ##1 instr_valid_i && instr_i[15:12] == 4'hf;
    endsequence
    sequence call_pair;
        take && instr_i[15:9] == 7'h76 ##1 instr_valid_i && instr_i[15:12] == 4'hf;
    endsequence
    chk_dest_route: assert property (
        byte_d |=> dest_to_acc_o == !$past(instr_i[9]) && file_write_o == $past(instr_i[9]))
        else $error("destination select routed wrongly");
    chk_bank_addr: assert property (
        byte_d |=> file_addr_o == {$past(instr_i[8]) ? $past(bank_select_register_i) : 4'h0,
        $past(instr_i[7:0])}) else $error("banked file address wrong");
    chk_move_pair: assert property (
        move_pair |=> alu_op_o == ALU_MOVE2 && file_write_o
        && move_dst_addr_o == $past(instr_i[11:0])) else $error("move destination wrong");
    chk_call_target: assert property (
        call_pair |=> jump_valid_o && fast_shadow_o == $past(instr_i[8], 2)
        && jump_target_o == {$past(instr_i[11:0]), $past(instr_i[7:0], 2)})
        else $error("call target or fast select wrong");
    chk_add_flags: assert property (
        take && instr_i[15:10] == 6'h09 |=> op_valid_o && alu_op_o == ALU_ADD
        && flag_mask_o == 5'h1f) else $error("add decode wrong");
    chk_logic_flags: assert property (
        take && instr_i[15:12] == 4'h1 |=> op_valid_o && flag_mask_o == 5'h14)
        else $error("logic op flags wrong");
    chk_mul_quiet: assert property (
        take && instr_i[15:9] == 7'h01 |=> alu_op_o == ALU_MUL && flag_mask_o == 5'h00
        && !file_write_o) else $error("multiply decode wrong");
    chk_skip_flush: assert property (
        take && test_true_i ##1 instr_valid_i |=> no_operation_o && !op_valid_o)
        else $error("word after true skip not flushed");
    chk_lone_second: assert property (
        take && instr_i[15:12] == 4'hf |=> no_operation_o && !file_write_o)
        else $error("lone second word not a no-operation");
endmodule
bind byte_op_instruction_decoder byte_op_instruction_decoder_monitor u_mon (
    .clk_i, .rst_i, .instr_i, .instr_valid_i, .bank_select_register_i, .test_true_i,
    .alu_op_o, .op_valid_o, .dest_to_acc_o, .file_write_o, .file_addr_o, .move_dst_addr_o,
    .jump_target_o, .jump_valid_o, .fast_shadow_o, .flag_mask_o, .no_operation_o
);

// >>> dv/byte_op_instruction_decoder_test.sv
// Self-checking bench for the byte-operation instruction decoder.
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
    $display("unexpected %s: expected %h, seen %h", nm, e, a); end end
module byte_op_instruction_decoder_test
    import decoder_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] instr_i;
    logic instr_valid_i, test_true_i, timer_zero_prescaler_assigned_i = 1'b0;
    logic [3:0] bank_select_register_i = 4'h0;
    logic [4:0] alu_op_o, flag_mask_o;
    logic [11:0] file_addr_o, move_dst_addr_o;
    logic [2:0] bit_sel_o;
    logic [7:0] literal_o;
    logic [19:0] jump_target_o;
    logic [10:0] branch_offset_o;
    logic op_valid_o, dest_to_acc_o, file_write_o, jump_valid_o, fast_shadow_o;
    logic read_pins_o, prescaler_clear_o, no_operation_o, multi_cycle_o;
    int miscompares = 0;
    int n_tests = 0;
    // Rows: instruction word, expected operation code, expected flag mask.
    logic [31:0] rows [30] = '{32'h2633011f, 32'h2233021f, 32'h16330314, 32'h12330414,
        32'h1a330514, 32'h1e330614, 32'h02330700, 32'h60330800, 32'h62330900, 32'h64330a00,
        32'h66330b00, 32'h68330c00, 32'h6a330d04, 32'h6c330e1f, 32'h6e330f00, 32'h0633101f,
        32'h2a33111f, 32'h2e331200, 32'h4e331300, 32'h3e331400, 32'h4a331500, 32'h36331615,
        32'h32331715, 32'h46331814, 32'h42331914, 32'h3a331a00, 32'h5e331b1f, 32'h5a331c1f,
        32'h56331d1f, 32'h52331e14};
    fetch_model m (.clk_i, .instr_o(instr_i), .instr_valid_o(instr_valid_i),
        .test_true_o(test_true_i));
    byte_op_instruction_decoder u_dut (.clk_i, .rst_i, .instr_i, .instr_valid_i,
        .bank_select_register_i, .test_true_i, .timer_zero_prescaler_assigned_i,
        .timer_zero_count_addr_i(12'h056), .port_addr_lo_i(12'h080), .port_addr_hi_i(12'h08f),
        .alu_op_o, .op_valid_o, .dest_to_acc_o, .file_write_o, .file_addr_o, .move_dst_addr_o,
        .bit_sel_o, .literal_o, .jump_target_o, .jump_valid_o, .fast_shadow_o,
        .branch_offset_o, .flag_mask_o, .read_pins_o, .prescaler_clear_o, .no_operation_o,
        .multi_cycle_o);
    // Free-running 125 MHz clock.
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end
    // Presents a single word, then lets its decoded outputs settle.
    task automatic op(input logic [15:0] w, input logic t);
        m.send(w, t);
        m.idle();
    endtask
    // Two-word call or jump, then a word that must be flushed.
    task automatic jump(input logic [15:0] w1, w2, input logic [19:0] tgt, input logic f);
        m.send(w1, 1'b0);
        op(w2, 1'b0);
        `CHK("jump_valid_o", 1'b1, jump_valid_o)
        `CHK("jump_target_o", tgt, jump_target_o)
        `CHK("fast_shadow_o", f, fast_shadow_o)
        op(16'h2633, 1'b0);
        `CHK("no_operation_o", 1'b1, no_operation_o)
        `CHK("op_valid_o", 1'b0, op_valid_o)
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && n_tests > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Cuts a hang short; the sequence needs about 114 cycles of the 3000 allowed.
    initial
    begin
        #(8 * 3000);
        miscompares++;
        print_verdict();
    end
    // Reset, the decode table, then the awkward cases by hand.
    initial
    begin
        repeat (12) @(negedge clk_i);
        `CHK("op_valid_o", 1'b0, op_valid_o)
        rst_i <= 1'b0;
        foreach (rows[i])
        begin
            op(rows[i][31:16], 1'b0);
            `CHK("alu_op_o", rows[i][12:8], alu_op_o)
            `CHK("flag_mask_o", rows[i][4:0], flag_mask_o)
            `CHK("file_write_o", !(rows[i][12:8] inside {[5'h07:5'h0b]}), file_write_o)
            `CHK("file_addr_o", 12'h033, file_addr_o)
        end
        bank_select_register_i <= 4'h5;
        op(16'h2533, 1'b0);
        `CHK("file_addr_o", 12'h533, file_addr_o)
        `CHK("dest_to_acc_o", 1'b1, dest_to_acc_o)
        `CHK("file_write_o", 1'b0, file_write_o)
        m.send(16'hc123, 1'b0);
        op(16'hf456, 1'b0);
        `CHK("alu_op_o", ALU_MOVE2, alu_op_o)
        `CHK("move_dst_addr_o", 12'h456, move_dst_addr_o)
        `CHK("file_addr_o", 12'h123, file_addr_o)
        jump(16'hed12, 16'hfabc, 20'habc12, 1'b1);
        jump(16'hec34, 16'hf567, 20'h56734, 1'b0);
        jump(16'hef78, 16'hf9ab, 20'h9ab78, 1'b0);
        op(16'hd7ff, 1'b0);
        `CHK("branch_offset_o", 11'h7ff, branch_offset_o)
        `CHK("multi_cycle_o", 1'b1, multi_cycle_o)
        op(16'h2633, 1'b0);
        `CHK("no_operation_o", 1'b1, no_operation_o)
        op(16'hf000, 1'b0);
        `CHK("no_operation_o", 1'b1, no_operation_o)
        m.send(16'h2e33, 1'b1);
        m.send(16'hc123, 1'b0);
        `CHK("multi_cycle_o", 1'b1, multi_cycle_o)
        op(16'hf456, 1'b0);
        `CHK("no_operation_o", 1'b1, no_operation_o)
        `CHK("op_valid_o", 1'b0, op_valid_o)
        op(16'h8a33, 1'b0);
        `CHK("bit_sel_o", 3'h5, bit_sel_o)
        `CHK("literal_o", 8'h33, literal_o)
        op(16'he2a5, 1'b0);
        `CHK("branch_offset_o", 11'h0a5, branch_offset_o)
        timer_zero_prescaler_assigned_i <= 1'b1;
        op(16'h2a56, 1'b0);
        `CHK("prescaler_clear_o", 1'b1, prescaler_clear_o)
        timer_zero_prescaler_assigned_i <= 1'b0;
        op(16'h2a56, 1'b0);
        `CHK("prescaler_clear_o", 1'b0, prescaler_clear_o)
        op(16'h5281, 1'b0);
        `CHK("read_pins_o", 1'b1, read_pins_o)
        op(16'h6e81, 1'b0);
        `CHK("read_pins_o", 1'b0, read_pins_o)
        print_verdict();
    end
endmodule
